// ---- verilog/frl_top.v ----
/*
 * Frequency reference shaping and stop control for a motor drive:
 * APB register file, reference selection and analog mapping, limiter,
 * start/stop sequencing and DC braking with a current ramp.
 * Assumes an external ramp generator that follows freq_target, presets
 * to it on ramp_load, and reports its present value on out_freq.
 */
// Notes on behaviour
// - In the run state, the target frequency is clamped between upper and lower limits.
// - A lower limit above the upper limit is ignored; upper applies.
// - An analog source maps through a line from bias to gain point.
// - Voltage input uses its gain pair, current input its own pair.
// - Bias/gain are parts of max frequency, base points of scale.
// - Below the bias base point the setting holds at the bias.
// - Above it the setting follows the slope/intercept expression.
// - A decelerated stop starts DC braking at the higher of brake and stop freq.
// - Brake frequency, level and time are three separate settings.
// - Response mode 0 ramps braking current slowly, 1 quickly.
// - Output starts at the starting frequency, ends at higher of stop/brake freq.
// - With start below stop, no output until reference beats stop.
`include "frl_regs.vh"
`default_nettype none

module frl_top #(
  parameter        AW           = 12,
  parameter [23:0] BRK_UNIT_CYC = `FRL_BRK_UNIT_CYC
) (
  input  wire          clk_sys,       // System clock, 250 MHz
  input  wire          rstn,          // Asynchronous reset, active low
  input  wire          ce,            // Clock enable, freezes state
  input  wire          psel,          // APB select
  input  wire          penable,       // APB enable
  input  wire          pwrite,        // APB write
  input  wire [7:0]    paddr,         // APB byte address
  input  wire [31:0]   pwdata,        // APB write data
  output reg  [31:0]   prdata,        // APB read data
  output wire          pready,        // APB ready
  output wire          pslverr,       // APB error, unmapped address
  input  wire          run_cmd,       // Run command pin
  input  wire [AW-1:0] ain_code,      // Analog reference ADC code
  input  wire [15:0]   out_freq,      // Present ramp output frequency
  output reg  [15:0]   freq_target,   // Frequency the ramp follows
  output reg           ramp_load,     // Preset ramp to freq_target
  output reg           out_enable,    // Power stage output on
  output reg           brake_active,  // DC braking in progress
  output reg  [15:0]   brake_current  // DC braking current, 0.1 %
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_RUN   = 5'h04;
  localparam [4:0] ST_DECEL = 5'h08;
  localparam [4:0] ST_BRAKE = 5'h10;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [1:0]  rst_sync;
  wire        rst_n;
  reg         run_meta;
  reg         run_s;
  reg  [15:0] cfg [0:`FRL_NUM_CFG-1];
  reg  [4:0]  state;
  reg  [4:0]  next_state;
  reg  [23:0] brk_pre;
  reg  [15:0] brk_ticks;
  wire [5:0]  idx;
  wire        setup;
  wire        access;
  wire        mapped;
  wire [1:0]  src;
  wire        quick;
  wire [15:0] step;
  wire [15:0] volt_freq;
  wire [15:0] curr_freq;
  reg  [15:0] ref_raw;
  wire [15:0] ref_lim;
  wire        start_lt_stop;
  wire        go;
  wire        stop_req;
  wire        at_brake;
  wire        brk_tick;
  wire        brk_done;
  integer     i;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function [15:0] rst_val;
    input [5:0] k;
    begin
      case (k)
        6'h01:   rst_val = `FRL_RST_MAX_FREQ;
        6'h02:   rst_val = `FRL_RST_UPPER;
        6'h04:   rst_val = `FRL_RST_START;
        6'h05:   rst_val = `FRL_RST_STOP;
        6'h08:   rst_val = `FRL_RST_GAIN;
        6'h09:   rst_val = `FRL_RST_GAIN_BASE;
        6'h0A:   rst_val = `FRL_RST_GAIN;
        6'h0B:   rst_val = `FRL_RST_GAIN_BASE;
        default: rst_val = `FRL_RST_ZERO;
      endcase
    end
  endfunction

  function [15:0] sat_add;
    input [15:0] a;
    input [15:0] b;
    input [15:0] lim;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > {1'b0, lim}) ? lim : s[15:0];
    end
  endfunction

  // Reference clear of the stop frequency; strict when start < stop
  function ref_clear;
    input [15:0] r;
    input [15:0] stop_f;
    input        strict_gt;
    begin
      ref_clear = strict_gt ? (r > stop_f) : (r >= stop_f);
    end
  endfunction

  function out_on;
    input [4:0] st;
    begin
      case (st)
        ST_START, ST_RUN, ST_DECEL: out_on = 1'b1;
        default:                    out_on = 1'b0;
      endcase
    end
  endfunction

  function [15:0] max16;
    input [15:0] a;
    input [15:0] b;
    begin
      max16 = (a > b) ? a : b;
    end
  endfunction

  // ****************************************************************
  // Reset release and run pin synchroniser
  // ****************************************************************
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_meta <= 1'b0;
      run_s    <= 1'b0;
    end else if (ce) begin
      run_meta <= run_cmd;
      run_s    <= run_meta;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign idx     = paddr[7:2];
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign mapped  = (paddr[1:0] == 2'h0) && (idx <= `FRL_LAST_IDX);
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `FRL_NUM_CFG; i = i + 1) begin
        cfg[i] <= rst_val(i[5:0]);
      end
    end else if (ce && access && pwrite && mapped &&
                 idx < `FRL_NUM_CFG) begin
      cfg[idx[3:0]] <= pwdata[15:0];
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup) begin
      case (paddr)
        `FRL_OFS_STATUS:  prdata <= {27'h0, state};
        `FRL_OFS_REF:     prdata <= {16'h0, ref_lim};
        `FRL_OFS_TARGET:  prdata <= {16'h0, freq_target};
        `FRL_OFS_BRK_CUR: prdata <= {16'h0, brake_current};
        default: begin
          if (mapped) begin
            prdata <= {16'h0, cfg[idx[3:0]]};
          end else begin
            prdata <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Reference selection, mapping and limiting
  // ****************************************************************
  assign src   = cfg[0][`FRL_SRC_MSB:`FRL_SRC_LSB];
  assign quick = cfg[0][`FRL_RESP_BIT];

  frl_map #(
    .AW        (AW)
  ) u_map_volt (
    .ain       (ain_code),
    .bias      (cfg[6][9:0]),
    .bias_base (cfg[7][9:0]),
    .gain      (cfg[8][9:0]),
    .gain_base (cfg[9][9:0]),
    .max_freq  (cfg[1]),
    .freq      (volt_freq)
  );

  frl_map #(
    .AW        (AW)
  ) u_map_curr (
    .ain       (ain_code),
    .bias      (cfg[6][9:0]),
    .bias_base (cfg[7][9:0]),
    .gain      (cfg[10][9:0]),
    .gain_base (cfg[11][9:0]),
    .max_freq  (cfg[1]),
    .freq      (curr_freq)
  );

  always @* begin
    case (src)
      `FRL_SRC_VOLTAGE: ref_raw = volt_freq;
      `FRL_SRC_CURRENT: ref_raw = curr_freq;
      default:          ref_raw = cfg[15];
    endcase
  end

  frl_limit u_limit (
    .ref_in  (ref_raw),
    .upper   (cfg[2]),
    .lower   (cfg[3]),
    .ref_out (ref_lim)
  );

  // ****************************************************************
  // Start, stop and braking sequence
  // ****************************************************************
  assign start_lt_stop = cfg[4] < cfg[5];
  assign go       = run_s &&
                    ref_clear(ref_raw, cfg[5], start_lt_stop);
  assign stop_req = !run_s ||
                    !ref_clear(ref_raw, cfg[5], start_lt_stop);
  // Brake at the higher of the brake and stop frequencies
  assign at_brake = (out_freq <= max16(cfg[12], cfg[5]));
  assign brk_tick = (brk_pre == BRK_UNIT_CYC - 24'h1);
  assign brk_done = brk_tick &&
                    ({1'b0, brk_ticks} + 17'h00001 >= {1'b0, cfg[14]});
  assign step     = quick ? `FRL_STEP_QUICK : `FRL_STEP_SLOW;

  always @* begin
    case (state)
      ST_IDLE: begin
        next_state = go ? ST_START : ST_IDLE;
      end
      ST_START: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = stop_req ? ST_DECEL : ST_RUN;
      end
      ST_DECEL: begin
        if (!stop_req) begin
          next_state = ST_RUN;
        end else if (at_brake) begin
          next_state = (cfg[14] != 16'h0) ? ST_BRAKE :
                       ST_IDLE;
        end else begin
          next_state = ST_DECEL;
        end
      end
      ST_BRAKE: begin
        next_state = brk_done ? ST_IDLE : ST_BRAKE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      freq_target   <= 16'h0000;
      ramp_load     <= 1'b0;
      out_enable    <= 1'b0;
      brake_active  <= 1'b0;
      brake_current <= 16'h0000;
      brk_pre       <= 24'h000000;
      brk_ticks     <= 16'h0000;
    end else if (ce) begin
      state      <= next_state;
      ramp_load  <= (next_state == ST_START);
      out_enable <= out_on(next_state);
      case (next_state)
        ST_START: freq_target <= cfg[4];
        ST_RUN:   freq_target <= ref_lim;
        default:  freq_target <= 16'h0000;
      endcase
      if (state == ST_BRAKE && next_state == ST_BRAKE) begin
        brake_active <= 1'b1;
        brk_pre      <= brk_tick ? 24'h000000 : brk_pre + 24'h1;
        if (brk_tick) begin
          brk_ticks     <= brk_ticks + 16'h1;
          brake_current <= sat_add(brake_current, step,
                                   cfg[13]);
        end
      end else if (next_state == ST_BRAKE) begin
        brake_active  <= 1'b1;
        brake_current <= 16'h0000;
        brk_pre       <= 24'h000000;
        brk_ticks     <= 16'h0000;
      end else begin
        brake_active  <= 1'b0;
        brake_current <= 16'h0000;
        brk_pre       <= 24'h000000;
        brk_ticks     <= 16'h0000;
      end
    end
  end

endmodule // frl_top

`default_nettype wire

// ---- verilog/frl_regs.vh ----
/*
 * Register map, field positions, reset values and timing counts of the
 * frequency reference, limiter and DC brake block.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef FRL_REGS_VH
`define FRL_REGS_VH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define FRL_OFS_CTRL       8'h00
`define FRL_OFS_MAX_FREQ   8'h04
`define FRL_OFS_UPPER      8'h08
`define FRL_OFS_LOWER      8'h0C
`define FRL_OFS_START      8'h10
`define FRL_OFS_STOP       8'h14
`define FRL_OFS_BIAS       8'h18
`define FRL_OFS_BIAS_BASE  8'h1C
`define FRL_OFS_VGAIN      8'h20
`define FRL_OFS_VGAIN_BASE 8'h24
`define FRL_OFS_CGAIN      8'h28
`define FRL_OFS_CGAIN_BASE 8'h2C
`define FRL_OFS_BRK_FREQ   8'h30
`define FRL_OFS_BRK_LEVEL  8'h34
`define FRL_OFS_BRK_TIME   8'h38
`define FRL_OFS_DIG_REF    8'h3C
`define FRL_OFS_STATUS     8'h40
`define FRL_OFS_REF        8'h44
`define FRL_OFS_TARGET     8'h48
`define FRL_OFS_BRK_CUR    8'h4C
`define FRL_NUM_CFG        16
`define FRL_LAST_IDX       6'h13

// ****************************************************************
// Control fields
// ****************************************************************
`define FRL_SRC_LSB        0
`define FRL_SRC_MSB        1
`define FRL_RESP_BIT       4
`define FRL_SRC_DIGITAL    2'h0
`define FRL_SRC_VOLTAGE    2'h1
`define FRL_SRC_CURRENT    2'h2

// ****************************************************************
// Reset values (frequencies in 0.01 Hz, percentages in 0.1 %)
// ****************************************************************
`define FRL_RST_MAX_FREQ   16'h1770
`define FRL_RST_UPPER      16'h1770
`define FRL_RST_GAIN       16'h03E8
`define FRL_RST_GAIN_BASE  16'h03E8
`define FRL_RST_START      16'h0064
`define FRL_RST_STOP       16'h0064
`define FRL_RST_ZERO       16'h0000

// ****************************************************************
// Scaling and timing
// ****************************************************************
`define FRL_PM_FULL        10'h3E8
`define FRL_CLK_PERIOD_NS  4
`define FRL_BRK_UNIT_NS    10000000
// One brake time unit (10 ms) in 4 ns clocks, sized for the 24-bit count
`define FRL_BRK_UNIT_CYC   24'h2625A0
`define FRL_STEP_SLOW      16'h0001
`define FRL_STEP_QUICK     16'h0014

`endif

// ---- verilog/frl_map.v ----
/*
 * Analog reference mapping: a bias/gain straight line from an ADC code
 * to a reference frequency.
 * Assumes an ADC code from logic on the same clock; purely combinational.
 */
`include "frl_regs.vh"
`default_nettype none

module frl_map #(
  parameter AW = 12
) (
  input  wire [AW-1:0] ain,        // ADC code, full scale = 100 %
  input  wire [9:0]    bias,       // Bias, 0.1 % of max frequency
  input  wire [9:0]    bias_base,  // Bias base point, 0.1 % of scale
  input  wire [9:0]    gain,       // Gain, 0.1 % of max frequency
  input  wire [9:0]    gain_base,  // Gain base point, 0.1 % of scale
  input  wire [15:0]   max_freq,   // Maximum frequency, 0.01 Hz
  output wire [15:0]   freq        // Reference frequency, 0.01 Hz
);

  wire        [AW+9:0] scaled;
  wire        [9:0]    ain_pm;
  wire        [9:0]    span;
  wire        [9:0]    dx;
  wire signed [11:0]   dg;
  wire signed [23:0]   num;
  wire signed [23:0]   quo;
  wire signed [23:0]   pct_s;
  wire        [9:0]    pct_line;
  wire        [9:0]    pct;
  wire                 hold_bias;
  wire        [25:0]   fprod;
  wire        [25:0]   fdiv;

  assign scaled   = ain * `FRL_PM_FULL;
  assign ain_pm   = scaled[AW+9:AW];
  assign span     = gain_base - bias_base;
  assign dx       = ain_pm - bias_base;
  assign dg       = $signed({2'h0, gain}) - $signed({2'h0, bias});
  assign num      = dg * $signed({1'b0, dx});
  assign quo      = num / $signed({14'h0000, span});
  assign pct_s    = quo + $signed({14'h0000, bias});
  // Saturate to 0..100 % so a steep line cannot wrap
  assign pct_line = (pct_s < 0) ? 10'h000 :
                    (pct_s > $signed({14'h0000, `FRL_PM_FULL})) ?
                    `FRL_PM_FULL : pct_s[9:0];
  // Below the bias base point, or with no usable span, hold the bias
  assign hold_bias = (ain_pm <= bias_base) ||
                     (gain_base <= bias_base);
  assign pct      = hold_bias ? bias : pct_line;
  assign fprod    = pct * max_freq;
  assign fdiv     = fprod / {16'h0000, `FRL_PM_FULL};
  assign freq     = fdiv[15:0];

endmodule // frl_map

`default_nettype wire

// ---- verilog/frl_limit.v ----
/*
 * Upper/lower frequency limiter.
 * Assumes settings from registers on the same clock; combinational.
 */
`include "frl_regs.vh"
`default_nettype none

module frl_limit (
  input  wire [15:0] ref_in,  // Unlimited reference, 0.01 Hz
  input  wire [15:0] upper,   // Upper frequency limit
  input  wire [15:0] lower,   // Lower frequency limit
  output wire [15:0] ref_out  // Limited reference
);

  wire        low_valid;
  wire [15:0] capped;

  assign low_valid = (lower <= upper);
  assign capped    = (ref_in > upper) ? upper : ref_in;
  assign ref_out   = (low_valid && capped < lower) ?
                     lower : capped;

endmodule // frl_limit

`default_nettype wire

// ---- dv/frl_top_sva.sv ----
/* Port-level assertions for frl_top.
   Assumes binding to frl_top; one clock clk_sys, reset rstn. */
`default_nettype none
module frl_top_sva #(
  parameter        AW           = 12,
  parameter [23:0] BRK_UNIT_CYC = 24'h000004
) (
  input wire logic          clk_sys,       // Clock
  input wire logic          rstn,          // Reset, active low
  input wire logic          ce,            // Clock enable
  input wire logic          psel,          // APB select
  input wire logic          penable,       // APB enable
  input wire logic          pwrite,        // APB write
  input wire logic [7:0]    paddr,         // APB address
  input wire logic [31:0]   pwdata,        // APB write data
  input wire logic [31:0]   prdata,        // APB read data
  input wire logic          pready,        // APB ready
  input wire logic          pslverr,       // APB error
  input wire logic          run_cmd,       // Run command
  input wire logic [AW-1:0] ain_code,      // ADC code
  input wire logic [15:0]   out_freq,      // Ramp output
  input wire logic [15:0]   freq_target,   // Ramp target
  input wire logic          ramp_load,     // Ramp preset
  input wire logic          out_enable,    // Output on
  input wire logic          brake_active,  // Braking
  input wire logic [15:0]   brake_current  // Braking current
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] up_lim;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ***
  // Shadow of the upper limit setting
  // ***
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      up_lim <= 16'h1770;
    else if (psel && penable && pwrite && ce && paddr == 8'h08)
      up_lim <= pwdata[15:0];
  end
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access not ready");
  property p_err;
    psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h4C) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("bad address not refused");
  property p_upper;
    out_enable && !ramp_load |-> freq_target <= $past(up_lim);
  endproperty
  a_upper: assert property (p_upper) else $error("target above limit");
  property p_load;
    ramp_load |=> !ramp_load;
  endproperty
  a_load: assert property (p_load) else $error("preset not a pulse");
  property p_start;
    $rose(out_enable) |-> ramp_load;
  endproperty
  a_start: assert property (p_start) else $error("start without preset");
  property p_brk_in;
    $rose(brake_active) |-> $fell(out_enable) && brake_current == 16'h0000;
  endproperty
  a_brk_in: assert property (p_brk_in) else $error("bad brake entry");
  property p_brk_off;
    brake_active |-> !out_enable;
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("output during brake");
  property p_ramp;
    brake_active && $past(brake_active) |-> brake_current >=
      $past(brake_current) && brake_current <= $past(brake_current) + 16'h0014;
  endproperty
  a_ramp: assert property (p_ramp) else $error("brake current step");
  property p_hold;
    $rose(brake_active) |-> brake_active [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("brake too short");
  c_start: cover property (ramp_load);
  c_brake: cover property ($rose(brake_active));
  c_err: cover property (psel && penable && pslverr);
endmodule // frl_top_sva

bind frl_top frl_top_sva #(.AW(AW), .BRK_UNIT_CYC(BRK_UNIT_CYC)) u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
  .ain_code(ain_code), .out_freq(out_freq), .freq_target(freq_target),
  .ramp_load(ramp_load), .out_enable(out_enable),
  .brake_active(brake_active), .brake_current(brake_current));
`default_nettype wire

// ---- dv/frl_ramp_model.sv ----
/* Far-side model: ADC sampling the analog reference and a ramp
   generator that follows freq_target and presets on ramp_load.
   Assumes the same clock and reset as frl_top. */
`default_nettype none
module frl_ramp_model #(
  parameter        AW   = 12,
  parameter [15:0] STEP = 16'h0032
) (
  input  wire logic          clk_sys,     // Clock
  input  wire logic          rstn,        // Reset, active low
  input  wire logic [AW-1:0] ain_lvl,     // Analog level
  input  wire logic          ramp_load,   // Preset request
  input  wire logic [15:0]   freq_target, // Target
  output var  logic [AW-1:0] ain_code,    // Sampled code
  output var  logic [15:0]   out_freq     // Ramp output
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ain_code <= '0;
      out_freq <= 16'h0000;
    end else begin
      ain_code <= ain_lvl;
      if (ramp_load)
        out_freq <= freq_target;
      else if (out_freq + STEP <= freq_target)
        out_freq <= out_freq + STEP;
      else if (out_freq >= freq_target + STEP)
        out_freq <= out_freq - STEP;
      else
        out_freq <= freq_target;
    end
  end
endmodule // frl_ramp_model
`default_nettype wire

// ---- dv/testbench.sv ----
/* Self-checking bench for frl_top with the ramp/ADC model.
   Assumes a short brake time unit of 4 clocks. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, run_cmd = 1'b0;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0, prdata;
  logic          pready, pslverr, ramp_load, out_enable, brake_active;
  logic [11:0]   ain_lvl = 12'h000, ain_code;
  logic [15:0]   out_freq, freq_target, brake_current;
  int            err_total = 0, checks = 0;

  always #2 clk_sys = ~clk_sys;

  frl_top #(.AW(12), .BRK_UNIT_CYC(24'h000004)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
    .ain_code(ain_code), .out_freq(out_freq), .freq_target(freq_target),
    .ramp_load(ramp_load), .out_enable(out_enable),
    .brake_active(brake_active), .brake_current(brake_current));
  frl_ramp_model #(.AW(12)) u_model (
    .clk_sys(clk_sys), .rstn(rstn), .ain_lvl(ain_lvl), .ramp_load(ramp_load),
    .freq_target(freq_target), .ain_code(ain_code), .out_freq(out_freq));

  task automatic complete_run;
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk($sformatf("reg %h", a), x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return ramp_load;
      1: return brake_active;
      2: return !brake_active;
      default: return out_enable && out_freq == freq_target;
    endcase
  endfunction

  task automatic wait_for(input int w, input string n);
    for (int i = 0; i < 400 && sig(w) !== 1'b1; i++) @(negedge clk_sys);
    chk(n, 32'h1, {31'h0, sig(w)});
  endtask

  function automatic int exp_map(int code, b, bb, g, gb, mx);
    int pm, p;
    pm = (code * 1000) >> 12;
    p = (pm <= bb || gb <= bb) ? b : b + (g - b) * (pm - bb) / (gb - bb);
    if (p > 1000) p = 1000;
    if (p < 0) p = 0;
    return p * mx / 1000;
  endfunction

  task automatic lim(input logic [15:0] r, input logic [15:0] x);
    wr(8'h3C, {16'h0, r});
    rd(8'h44, {16'h0, x}, 1'b0);
  endtask

  // ***
  // Scenarios
  // ***
  task automatic t_regs;
    logic [7:0]  ad [0:9];
    logic [15:0] rv [0:9];
    ad = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2C,
           8'h40};
    rv = '{16'h1770, 16'h1770, 16'h0000, 16'h0064, 16'h0064, 16'h03E8,
           16'h03E8, 16'h03E8, 16'h03E8, 16'h0001};
    for (int i = 0; i < 10; i++) rd(ad[i], {16'h0, rv[i]}, 1'b0);
    wr(8'h18, 32'hABCD1234);
    rd(8'h18, 32'h00001234, 1'b0);
    wr(8'h48, 32'h0000FFFF);
    rd(8'h48, 32'h0, 1'b0);
    rd(8'h50, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    wr(8'h18, 32'h0);
  endtask

  task automatic t_limit;
    wr(8'h08, 32'd5000);
    wr(8'h0C, 32'd1000);
    lim(16'd5500, 16'd5000);
    lim(16'd500, 16'd1000);
    lim(16'd3000, 16'd3000);
    wr(8'h0C, 32'd5200);
    lim(16'd500, 16'd500);
    lim(16'd5500, 16'd5000);
    wr(8'h08, 32'd6000);
    wr(8'h0C, 32'd0);
  endtask

  task automatic t_map;
    int codes [0:3];
    codes = '{205, 1024, 2048, 4095};
    wr(8'h00, 32'h1);
    wr(8'h18, 32'd100);
    wr(8'h1C, 32'd100);
    wr(8'h20, 32'd900);
    wr(8'h24, 32'd500);
    foreach (codes[i]) begin
      @(posedge clk_sys);
      ain_lvl <= codes[i][11:0];
      rd(8'h44, exp_map(codes[i], 100, 100, 900, 500, 6000), 1'b0);
    end
    ain_lvl <= 12'h800;
    wr(8'h00, 32'h2);
    rd(8'h44, exp_map(2048, 100, 100, 1000, 1000, 6000), 1'b0);
    wr(8'h00, 32'h0);
  endtask

  task automatic t_brake;
    int n, peak;
    wr(8'h3C, 32'd3000);
    wr(8'h30, 32'd500);
    wr(8'h34, 32'd30);
    wr(8'h38, 32'd3);
    wr(8'h0C, 32'd100);
    for (int m = 0; m < 2; m++) begin
      wr(8'h00, m << 4);
      @(posedge clk_sys);
      run_cmd <= 1'b1;
      wait_for(0, "ramp_load");
      chk("start target", 32'd100, {16'h0, freq_target});
      wait_for(3, "at target");
      chk("run target", 32'd3000, {16'h0, freq_target});
      @(posedge clk_sys);
      run_cmd <= 1'b0;
      wait_for(1, "brake_active");
      chk("brake freq", 32'h1, {31'h0, out_freq <= 16'd500});
      n = 0;
      peak = 0;
      while (brake_active === 1'b1 && n < 100) begin
        n++;
        peak = brake_current;
        @(negedge clk_sys);
      end
      chk("brake time", 32'h1, {31'h0, n >= 11 && n <= 13});
      chk("peak", 32'h1, m ? peak == 30 : peak >= 2 && peak <= 3);
    end
    wr(8'h00, 32'h0);
  endtask

  task automatic t_low_start;
    logic seen;
    seen = 1'b0;
    wr(8'h14, 32'd800);
    wr(8'h0C, 32'd800);
    wr(8'h3C, 32'd800);
    @(posedge clk_sys);
    run_cmd <= 1'b1;
    repeat (30) begin
      @(negedge clk_sys);
      seen = seen | out_enable;
    end
    chk("no output", 32'h0, {31'h0, seen});
    wr(8'h3C, 32'd801);
    wait_for(0, "ramp_load");
    chk("start target", 32'd100, {16'h0, freq_target});
    wait_for(3, "at target");
    wr(8'h3C, 32'd500);
    wait_for(1, "brake_active");
    wait_for(2, "brake end");
    @(posedge clk_sys);
    run_cmd <= 1'b0;
    wr(8'h14, 32'd100);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_limit();
    t_map();
    t_brake();
    t_low_start();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
